// ### dcs_map.svh
// constants for the daisy-chain serial control port
`ifndef DCS_MAP_SVH
`define DCS_MAP_SVH

// control byte field positions
`define DCS_CB_BCAST 7
`define DCS_CB_DIR 6
`define DCS_CB_SPACE 5
`define DCS_CB_RSVD 4
// field values
`define DCS_DIR_READ 1'b1
`define DCS_SPACE_REG 1'b1
// widths
`define DCS_ADDR_W 7
`define DCS_REG_W 8
`define DCS_RAM_W 16
`define DCS_CID_W 4
// bit counter positions inside a byte
`define DCS_BIT_LAST 3'h7
`define DCS_BIT_CID_FIRST 3'h4
`define DCS_BIT_CID_DEC 3'h5
// channel index values this device answers to
`define DCS_CID_CH0 4'h0
`define DCS_CID_CH1 4'h1
// reset values
`define DCS_LVL_RST 3'h3
`define DCS_SH_RST 16'h0000

`endif

// ### dcs_pkg.sv
// types shared by the daisy-chain serial control port
package dcs_pkg;
  typedef enum logic [1:0] {
    ST_CTRL  = 2'b00,
    ST_ADDR  = 2'b01,
    ST_DATA1 = 2'b10,
    ST_DATA2 = 2'b11
  } dcs_state_t;
endpackage

// ### dcs_ram_chan.sv
// per-channel ram request buffers and pending flag
`timescale 1ns/1ps
`default_nettype none
`include "dcs_map.svh"
module dcs_ram_chan (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic wr_req_i,
  input wire logic rd_req_i,
  input wire logic [`DCS_ADDR_W-1:0] addr_i,
  input wire logic [`DCS_RAM_W-1:0] wdata_i,
  input wire logic svc_done_i,
  input wire logic [`DCS_RAM_W-1:0] svc_rdata_i,
  input wire logic irq_en_i,
  output logic pending_o,
  output logic write_o,
  output logic [`DCS_ADDR_W-1:0] addr_buf_o,
  output logic [`DCS_RAM_W-1:0] data_buf_o,
  output logic done_o
);
  logic pend, next_pend;
  logic dir_wr, next_dir_wr;
  logic [`DCS_ADDR_W-1:0] abuf, next_abuf;
  logic [`DCS_RAM_W-1:0] dbuf, next_dbuf;
  logic done, next_done;

  // service completion first, then a new request, so a set wins
  always_comb begin
    next_pend = pend;
    next_dir_wr = dir_wr;
    next_abuf = abuf;
    next_dbuf = dbuf;
    next_done = 1'b0;
    if (svc_done_i && pend) begin
      next_pend = 1'b0;
      next_done = irq_en_i;
      if (!dir_wr) begin
        next_dbuf = svc_rdata_i;
      end
    end
    if (wr_req_i || rd_req_i) begin
      next_pend = 1'b1;
      next_abuf = addr_i;
      next_dir_wr = wr_req_i;
      if (wr_req_i) begin
        next_dbuf = wdata_i;
      end
    end
  end

  // state registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pend <= 1'b0;
      dir_wr <= 1'b0;
      abuf <= '0;
      dbuf <= `DCS_SH_RST;
      done <= 1'b0;
    end else if (ce_i) begin
      pend <= next_pend;
      dir_wr <= next_dir_wr;
      abuf <= next_abuf;
      dbuf <= next_dbuf;
      done <= next_done;
    end
  end

  assign pending_o = pend;
  assign write_o = dir_wr;
  assign addr_buf_o = abuf;
  assign data_buf_o = dbuf;
  assign done_o = done;
endmodule
`default_nettype wire

// ### dcs_spi_port.sv
// two-channel daisy-chain serial control port, sampled on the system clock
`timescale 1ns/1ps
`default_nettype none
`include "dcs_map.svh"
// What this block does
// - bit 7 requests chain-wide write
// - bit 6 selects write or read
// - bit 5 selects ram or register space
// - four-bit channel index sent lsb first
// - index decremented per channel, two per device
// - only channel seeing index zero acts
// - chain-wide: index unchanged, all channels accept
// - top three control bits forwarded unchanged
// - select high after register data means one byte
// - serial input ignored during read data
// - no select rise means eight more clocks
// - 16-bit register write drops last byte
// - 16-bit register read repeats the byte
// - register read loads after address byte
// - register write commits after data byte
// - ram access always four bytes long
// - ram read returns previous buffered result
// - ram read logs address and pending request
// - pending flag and done pulse per channel
// - ram write fills per-channel buffers
// - control, 7-bit address, data, msb first
// - select rise off byte boundary resets
module dcs_spi_port (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  output logic chain_pass_out_o,
  output logic [1:0] reg_wr_o,
  output logic [`DCS_ADDR_W-1:0] reg_addr_o,
  output logic [`DCS_REG_W-1:0] reg_wdata_o,
  input wire logic [`DCS_REG_W-1:0] reg_rdata0_i,
  input wire logic [`DCS_REG_W-1:0] reg_rdata1_i,
  output logic [1:0] ram_request_pending_flag_o,
  output logic [1:0] ram_write_o,
  output logic [1:0][`DCS_ADDR_W-1:0] ram_addr_o,
  output logic [1:0][`DCS_RAM_W-1:0] ram_wdata_o,
  input wire logic [1:0] ram_svc_done_i,
  input wire logic [1:0][`DCS_RAM_W-1:0] ram_svc_rdata_i,
  input wire logic [1:0] ram_irq_en_i,
  output logic [1:0] ram_done_o
);
  // ****************************************************************
  // reset release
  // ****************************************************************
  logic [1:0] rst_sync;
  logic rst_n;

  // async assert, clocked release
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ****************************************************************
  // pin synchronisers, bit order {sdi, cs_n, sclk}
  // ****************************************************************
  logic [2:0] s1, s2, s3, lvl, next_lvl;

  // a level counts only once the second and third stages agree
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      next_lvl[i] = (s2[i] == s3[i]) ? s3[i] : lvl[i];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= `DCS_LVL_RST;
      s2 <= `DCS_LVL_RST;
      s3 <= `DCS_LVL_RST;
      lvl <= `DCS_LVL_RST;
    end else if (ce_i) begin
      s1 <= {sdi_i, cs_n_i, sclk_i};
      s2 <= s1;
      s3 <= s2;
      lvl <= next_lvl;
    end
  end

  logic sclk_rise, sclk_fall, cs_low, cs_rise, sdi_b;
  assign sclk_rise = next_lvl[0] & ~lvl[0];
  assign sclk_fall = ~next_lvl[0] & lvl[0];
  assign cs_low = ~lvl[1];
  assign cs_rise = next_lvl[1] & ~lvl[1];
  assign sdi_b = lvl[2];

  // ****************************************************************
  // serial state machine
  // ****************************************************************
  dcs_pkg::dcs_state_t state, next_state;
  logic [2:0] bit_cnt, next_bit_cnt;
  logic [7:0] ctrl, next_ctrl;
  logic [7:0] addr, next_addr;
  logic [15:0] dsh, next_dsh;
  logic [15:0] osh, next_osh;
  logic [1:0] tgt, next_tgt;
  logic ld_pend, next_ld_pend;
  logic sdo_q, next_sdo_q;
  logic oe_q, next_oe_q;
  logic [1:0] reg_wr, next_reg_wr;
  logic [1:0] ram_wr, next_ram_wr;
  logic [1:0] ram_rd, next_ram_rd;
  logic bcast, is_read, is_reg;
  logic [1:0] rd_tgt;
  logic [7:0] full_byte;
  logic [3:0] cid;
  logic [1:0][`DCS_RAM_W-1:0] ram_dbuf;

  assign bcast = ctrl[`DCS_CB_BCAST];
  assign is_read = (ctrl[`DCS_CB_DIR] == `DCS_DIR_READ);
  assign is_reg = (ctrl[`DCS_CB_SPACE] == `DCS_SPACE_REG);
  // a chain-wide read would fight other outputs, so it never drives
  assign rd_tgt = bcast ? 2'b00 : tgt;
  assign full_byte = {ctrl[6:0], sdi_b};
  // index arrives lsb first in the low nibble
  assign cid = {full_byte[0], full_byte[1], full_byte[2], full_byte[3]};

  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_ctrl = ctrl;
    next_addr = addr;
    next_dsh = dsh;
    next_osh = osh;
    next_tgt = tgt;
    next_ld_pend = 1'b0;
    next_sdo_q = sdo_q;
    next_reg_wr = 2'b00;
    next_ram_wr = 2'b00;
    next_ram_rd = 2'b00;
    if (cs_rise) begin
      if (bit_cnt != 3'h0) begin
        // off a byte boundary: force back to a known state
        next_state = dcs_pkg::ST_CTRL;
        next_bit_cnt = 3'h0;
      end else if (state == dcs_pkg::ST_DATA2 && is_reg) begin
        next_state = dcs_pkg::ST_CTRL;
      end
    end else if (cs_low && sclk_rise) begin
      next_bit_cnt = bit_cnt + 3'h1;
      case (state)
        dcs_pkg::ST_CTRL: begin
          next_ctrl = full_byte;
          if (bit_cnt == `DCS_BIT_LAST) begin
            next_tgt[0] = full_byte[`DCS_CB_BCAST] | (cid == `DCS_CID_CH0);
            next_tgt[1] = full_byte[`DCS_CB_BCAST] | (cid == `DCS_CID_CH1);
            next_state = dcs_pkg::ST_ADDR;
          end
        end
        dcs_pkg::ST_ADDR: begin
          next_addr = {addr[6:0], sdi_b};
          if (bit_cnt == `DCS_BIT_LAST) begin
            next_ld_pend = is_read;
            next_state = dcs_pkg::ST_DATA1;
          end
        end
        dcs_pkg::ST_DATA1: begin
          // input bits during a read land in dsh and are never used
          next_dsh = {dsh[14:0], sdi_b};
          if (bit_cnt == `DCS_BIT_LAST) begin
            if (is_reg && !is_read) begin
              next_reg_wr = tgt;
            end
            next_state = dcs_pkg::ST_DATA2;
          end
        end
        dcs_pkg::ST_DATA2: begin
          // register writes already committed, so this byte is dropped
          next_dsh = {dsh[14:0], sdi_b};
          if (bit_cnt == `DCS_BIT_LAST) begin
            if (!is_reg) begin
              next_ram_wr = is_read ? 2'b00 : tgt;
              next_ram_rd = is_read ? rd_tgt : 2'b00;
            end
            next_state = dcs_pkg::ST_CTRL;
          end
        end
        default: begin
          next_state = dcs_pkg::ST_CTRL;
        end
      endcase
    end
    // load one clock after the address byte so the read port has settled
    if (ld_pend) begin
      if (is_reg) begin
        next_osh = rd_tgt[1] ? {reg_rdata1_i, reg_rdata1_i}
                             : {reg_rdata0_i, reg_rdata0_i};
      end else begin
        next_osh = rd_tgt[1] ? ram_dbuf[1] : ram_dbuf[0];
      end
    end else if (cs_low && sclk_fall &&
                 (state == dcs_pkg::ST_DATA1 || state == dcs_pkg::ST_DATA2)) begin
      next_sdo_q = osh[15];
      next_osh = {osh[14:0], 1'b0};
    end
    next_oe_q = cs_low && is_read && (rd_tgt != 2'b00) &&
                (state == dcs_pkg::ST_DATA1 || state == dcs_pkg::ST_DATA2);
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= dcs_pkg::ST_CTRL;
      bit_cnt <= 3'h0;
      ctrl <= 8'h00;
      addr <= 8'h00;
      dsh <= `DCS_SH_RST;
      osh <= `DCS_SH_RST;
      tgt <= 2'b00;
      ld_pend <= 1'b0;
      sdo_q <= 1'b0;
      oe_q <= 1'b0;
      reg_wr <= 2'b00;
      ram_wr <= 2'b00;
      ram_rd <= 2'b00;
    end else if (ce_i) begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      ctrl <= next_ctrl;
      addr <= next_addr;
      dsh <= next_dsh;
      osh <= next_osh;
      tgt <= next_tgt;
      ld_pend <= next_ld_pend;
      sdo_q <= next_sdo_q;
      oe_q <= next_oe_q;
      reg_wr <= next_reg_wr;
      ram_wr <= next_ram_wr;
      ram_rd <= next_ram_rd;
    end
  end

  assign sdo_o = sdo_q;
  assign sdo_oe_o = oe_q;
  assign reg_wr_o = reg_wr;
  // only the seven low address bits reach the channels
  assign reg_addr_o = addr[`DCS_ADDR_W-1:0];
  assign reg_wdata_o = dsh[7:0];

  // ****************************************************************
  // chain forwarding with serial index decrement
  // ****************************************************************
  logic chain_q, next_chain_q;
  logic borrow, next_borrow;
  logic in_cid, sub_b, b_in, bcast_now;

  // chain-wide bit is still walking up ctrl here, so ctrl[7] holds a stale byte
  assign bcast_now = ctrl[bit_cnt - 3'h1];
  // the nibble is lsb first, so a ripple borrow subtracts two on the fly
  assign in_cid = (state == dcs_pkg::ST_CTRL) && (bit_cnt >= `DCS_BIT_CID_FIRST) &&
                  !bcast_now;
  assign sub_b = (bit_cnt == `DCS_BIT_CID_DEC);
  assign b_in = (bit_cnt == `DCS_BIT_CID_FIRST) ? 1'b0 : borrow;

  always_comb begin
    next_borrow = borrow;
    // upper bits, reserved bit and all later bytes pass untouched
    next_chain_q = in_cid ? (sdi_b ^ sub_b ^ b_in) : sdi_b;
    if (in_cid && cs_low && sclk_rise) begin
      next_borrow = (~sdi_b & (sub_b | b_in)) | (sdi_b & sub_b & b_in);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      chain_q <= 1'b1;
      borrow <= 1'b0;
    end else if (ce_i) begin
      chain_q <= next_chain_q;
      borrow <= next_borrow;
    end
  end
  assign chain_pass_out_o = chain_q;

  // ****************************************************************
  // per-channel ram request buffers
  // ****************************************************************
  for (genvar g = 0; g < 2; g++) begin : g_chan
    dcs_ram_chan u_chan (
      .clk_i(clk_i),
      .rst_n_i(rst_n),
      .ce_i(ce_i),
      .wr_req_i(ram_wr[g]),
      .rd_req_i(ram_rd[g]),
      .addr_i(addr[`DCS_ADDR_W-1:0]),
      .wdata_i(dsh),
      .svc_done_i(ram_svc_done_i[g]),
      .svc_rdata_i(ram_svc_rdata_i[g]),
      .irq_en_i(ram_irq_en_i[g]),
      .pending_o(ram_request_pending_flag_o[g]),
      .write_o(ram_write_o[g]),
      .addr_buf_o(ram_addr_o[g]),
      .data_buf_o(ram_dbuf[g]),
      .done_o(ram_done_o[g])
    );
    assign ram_wdata_o[g] = ram_dbuf[g];
  end
endmodule
`default_nettype wire

// ### dcs_spi_port_properties.sv
// assertion checker for the daisy-chain serial control port
`timescale 1ns/1ps
`default_nettype none
module dcs_spi_port_properties (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic cs_n_i,
  input wire logic sdo_oe_o,
  input wire logic [1:0] reg_wr_o,
  input wire logic [1:0] ram_request_pending_flag_o,
  input wire logic [1:0] ram_write_o,
  input wire logic [1:0][15:0] ram_wdata_o,
  input wire logic [1:0] ram_svc_done_i,
  input wire logic [1:0][15:0] ram_svc_rdata_i,
  input wire logic [1:0] ram_irq_en_i,
  input wire logic [1:0] ram_done_o
);
  // ******************
  // port properties
  // ******************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);
  // eight idle cycles cover the three-flop select sampling
  a_oe_idle_off: assert property (cs_n_i [*8] |-> !sdo_oe_o)
    else $error("sdo driven with select idle");
  a_wr_pulse_one: assert property (|reg_wr_o |=> reg_wr_o == 2'h0)
    else $error("write strobe longer than one cycle");
  a_wr_in_frame: assert property (|reg_wr_o |-> !$past(cs_n_i, 4))
    else $error("write strobe outside a frame");
  a_oe_rise_frame: assert property ($rose(sdo_oe_o) |-> !$past(cs_n_i, 3))
    else $error("sdo enabled without select");
  a_rd_no_write: assert property (sdo_oe_o |-> reg_wr_o == 2'h0)
    else $error("register written during a read");
  a_done_cause: assert property (ram_done_o[0] |->
    $past(ram_svc_done_i[0]) && $past(ram_request_pending_flag_o[0])
    && $past(ram_irq_en_i[0]))
    else $error("done pulse without cause");
  a_done_one: assert property (ram_done_o[0] |=> !ram_done_o[0])
    else $error("done pulse too long");
  // quiet link so no new request can race the service
  a_pend_clear: assert property (cs_n_i [*8] ##0
    (ram_svc_done_i[0] && ram_request_pending_flag_o[0])
    |=> !ram_request_pending_flag_o[0])
    else $error("pending not cleared by service");
  a_rd_result_load: assert property (cs_n_i [*8] ##0 (ram_svc_done_i[0]
    && ram_request_pending_flag_o[0] && !ram_write_o[0])
    |=> ram_wdata_o[0] == $past(ram_svc_rdata_i[0]))
    else $error("read result not buffered");
  a_pend_hold: assert property (cs_n_i [*8] ##0 !ram_svc_done_i[0]
    |=> $stable(ram_request_pending_flag_o[0]))
    else $error("pending changed with link idle");
  c_write: cover property (|reg_wr_o);
  c_read: cover property ($rose(sdo_oe_o));
  c_done: cover property (ram_done_o[0]);
endmodule
bind dcs_spi_port dcs_spi_port_properties dcs_spi_port_properties_i (.*);
`default_nettype wire

// ### dcs_host_model.sv
// serial controller model driving the control port link
`timescale 1ns/1ps
`default_nettype none
module dcs_host_model (
  input wire logic clk_i,
  input wire logic sdo_i,
  input wire logic chain_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic sdi_o
);
  // single device on the chain, its pass output returned to the host
  initial begin
    sclk_o = 1'b1;
    cs_n_o = 1'b1;
    sdi_o = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // select moves only while the serial clock idles high; released data line flips
  task automatic sel(input logic v);
    sdi_o <= ~sdi_o;
    tick(8);
    cs_n_o <= v;
    tick(8);
  endtask
  // n bits msb first, 64 ns clock: drive on fall, sample on rise
  task automatic xfer(input logic [7:0] b, input int n, output logic [7:0] r,
                      output logic [7:0] c);
    for (int i = 7; i > 7 - n; i--) begin
      sclk_o <= 1'b0;
      sdi_o <= b[i];
      tick(8);
      // chain output is only valid before the rising edge moves the bit counter
      r[i] = sdo_i;
      c[i] = chain_i;
      sclk_o <= 1'b1;
      tick(8);
    end
  endtask
endmodule
`default_nettype wire

// ### dcs_spi_port_test.sv
// self-checking bench for the daisy-chain serial control port
`timescale 1ns/1ps
`default_nettype none
module dcs_spi_port_test;
  logic clk_i, arst_n_i, ce_i, sclk_i, cs_n_i, sdi_i, sdo_o, sdo_oe_o;
  logic chain_pass_out_o, clr;
  logic [1:0] reg_wr_o, ram_request_pending_flag_o, ram_write_o, ram_svc_done_i;
  logic [1:0] ram_irq_en_i, ram_done_o, wr_seen, done_seen;
  logic [6:0] reg_addr_o, wa;
  logic [7:0] reg_wdata_o, reg_rdata0_i, reg_rdata1_i, wd, r, ch, rh;
  logic [1:0][6:0] ram_addr_o;
  logic [1:0][15:0] ram_wdata_o, ram_svc_rdata_i;
  logic [15:0] rr;
  int miscompares, n_compared;
  // ctrl, addr, data, strobes, read byte, forwarded ctrl
  logic [47:0] rows [7] = '{48'h2091A5010027, 48'h28225A02002F, 48'h243366000020,
    48'hA444990300A4, 48'h6055FF003C67, 48'h68660000C36F, 48'h30770F010037};
  dcs_spi_port dcs_spi_port_i (.*);
  // released sdo floats high through its pull-up
  dcs_host_model dcs_host_model_i (.clk_i(clk_i), .sdo_i(sdo_oe_o ? sdo_o : 1'b1),
    .chain_i(chain_pass_out_o), .sclk_o(sclk_i), .cs_n_o(cs_n_i), .sdi_o(sdi_i));
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // strobes are one cycle wide, so accumulate them
  always @(posedge clk_i) begin
    if (clr) begin
      wr_seen <= 2'h0;
      done_seen <= 2'h0;
    end else begin
      wr_seen <= wr_seen | reg_wr_o;
      done_seen <= done_seen | ram_done_o;
      if (|reg_wr_o) begin
        wa <= reg_addr_o;
        wd <= reg_wdata_o;
      end
    end
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic print_verdict();
    if (miscompares == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic clear();
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
  endtask
  // one byte under its own select, eight-bit style
  task automatic op(input logic [7:0] b);
    dcs_host_model_i.sel(1'b0);
    dcs_host_model_i.xfer(b, 8, r, ch);
    dcs_host_model_i.sel(1'b1);
    rr = {rr[7:0], r};
  endtask
  task automatic ops(input logic [31:0] v, input int n);
    clear();
    for (int i = n - 1; i >= 0; i--) begin
      op(v[i*8+:8]);
      if (i == n - 1)
        rh = ch;
    end
  endtask
  // sixteen-bit style: select held across all four bytes
  task automatic word4(input logic [31:0] v);
    clear();
    dcs_host_model_i.sel(1'b0);
    for (int i = 3; i >= 0; i--) begin
      dcs_host_model_i.xfer(v[i*8+:8], 8, r, ch);
      rr = {rr[7:0], r};
    end
    dcs_host_model_i.sel(1'b1);
  endtask
  task automatic svc();
    clear();
    ram_svc_done_i <= 2'h1;
    @(posedge clk_i);
    ram_svc_done_i <= 2'h0;
    repeat (4) @(posedge clk_i);
  endtask
  // watchdog, about eight and a half times the expected run
  initial begin
    repeat (60000) @(posedge clk_i);
    miscompares++;
    print_verdict();
  end
  initial begin
    logic [7:0] c, a, d, w, q, p;
    arst_n_i = 1'b0;
    ce_i = 1'b1;
    clr = 1'b0;
    reg_rdata0_i = 8'h3C;
    reg_rdata1_i = 8'hC3;
    ram_svc_done_i = 2'h0;
    ram_svc_rdata_i = '0;
    ram_irq_en_i = 2'h1;
    repeat (10) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    for (int k = 0; k < 7; k++) begin
      {c, a, d, w, q, p} = rows[k];
      ops({8'h00, c, a, d}, 3);
      chk("chain", p, rh);
      chk("strobe", w, wr_seen);
      if (c[6])
        chk("rdata", q, r);
      else if (|w) begin
        chk("waddr", a & 8'h7F, wa);
        chk("wdata", d, wd);
      end
    end
    reg_rdata0_i <= 8'h5A;
    word4(32'h60550000);
    chk("rd16", 16'h5A5A, rr);
    word4(32'h20109669);
    chk("wd16", 8'h96, wd);
    chk("st16", 2'h1, wr_seen);
    // abort after three bits, then a clean write must land
    dcs_host_model_i.sel(1'b0);
    dcs_host_model_i.xfer(8'hFF, 3, r, ch);
    dcs_host_model_i.sel(1'b1);
    ops(32'h0028447E, 3);
    chk("resync", 8'h7E, wd);
    ops(32'h0012ABCD, 4);
    chk("pend", 2'h1, ram_request_pending_flag_o);
    chk("rwdata", 16'hABCD, ram_wdata_o[0]);
    chk("raddr", 7'h12, ram_addr_o[0]);
    svc();
    chk("done", 2'h1, done_seen);
    chk("pend", 2'h0, ram_request_pending_flag_o);
    ram_irq_en_i <= 2'h0;
    ram_svc_rdata_i <= {16'h0000, 16'h1234};
    ops(32'h40130000, 4);
    chk("rpipe", 16'hABCD, rr);
    chk("raddr", 7'h13, ram_addr_o[0]);
    chk("rdir", 1'b0, ram_write_o[0]);
    ops(32'h08215566, 4);
    chk("pend2", 2'h3, ram_request_pending_flag_o);
    chk("rwd1", 16'h5566, ram_wdata_o[1]);
    // clock enable low: a service pulse must not touch the frozen flags
    ce_i <= 1'b0;
    ram_svc_done_i <= 2'h2;
    @(posedge clk_i);
    ram_svc_done_i <= 2'h0;
    repeat (2) @(posedge clk_i);
    chk("freeze", 2'h3, ram_request_pending_flag_o);
    ce_i <= 1'b1;
    svc();
    chk("masked", 2'h0, done_seen);
    chk("rload", 16'h1234, ram_wdata_o[0]);
    chk("pend3", 2'h2, ram_request_pending_flag_o);
    arst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk("rst", 16'h0001, {ram_request_pending_flag_o, sdo_oe_o, chain_pass_out_o});
    print_verdict();
  end
endmodule
`default_nettype wire
